//--- rtl/tdq_pkg.sv
// Constants shared by the touch detection qualifier and its helpers.
// Assumes byte addressing on a 32-bit Avalon-MM register port.
package tdq_pkg;
  localparam int TDQ_NCH  = 16;   // Sensing channels
  localparam int TDQ_CHW  = 4;    // Channel index width
  localparam int TDQ_CW   = 4;    // Detection counter width
  localparam int TDQ_SW   = 12;   // Sample width
  localparam int TDQ_DW   = 14;   // Signed delta width
  localparam int TDQ_NGP  = 3;    // General-purpose pins
  localparam int TDQ_AW   = 8;    // Byte address width
  localparam int TDQ_TCW  = 5;    // Touch count width
  localparam int TDQ_FSW  = 3;    // Acquisition setting index width
  localparam int TDQ_BEND_SHIFT = 3;

  localparam logic [TDQ_AW-1:0] TDQ_A_CTRL = 8'h00;
  localparam logic [TDQ_AW-1:0] TDQ_A_THR  = 8'h04;
  localparam logic [TDQ_AW-1:0] TDQ_A_LIM  = 8'h08;
  localparam logic [TDQ_AW-1:0] TDQ_A_GCL  = 8'h0C;
  localparam logic [TDQ_AW-1:0] TDQ_A_GRIP = 8'h10;
  localparam logic [TDQ_AW-1:0] TDQ_A_FACT = 8'h14;
  localparam logic [TDQ_AW-1:0] TDQ_A_GPIO = 8'h18;
  localparam logic [TDQ_AW-1:0] TDQ_A_STAT = 8'h1C;

  // Control bits
  localparam int TDQ_C_GC    = 0;
  localparam int TDQ_C_NC    = 1;
  localparam int TDQ_C_FACT  = 2;
  localparam int TDQ_C_DUALX = 3;
  localparam int TDQ_C_GRIP  = 4;
  localparam int TDQ_C_SWN   = 5;
  localparam int TDQ_C_BEND  = 6;
  localparam int TDQ_C_CAL   = 7;
  localparam int TDQ_CTRLW   = 7;

  // Field positions
  localparam int TDQ_THR_LSB  = 0;
  localparam int TDQ_STHR_LSB = 16;
  localparam int TDQ_LIM_LSB  = 0;
  localparam int TDQ_MAXT_LSB = 8;
  localparam int TDQ_LRG_LSB  = 16;
  localparam int TDQ_FVAL_LSB = 0;
  localparam int TDQ_FIDX_LSB = 16;
  localparam int TDQ_GOUT_LSB = 0;
  localparam int TDQ_GDIR_LSB = 4;
  localparam int TDQ_GIN_LSB  = 8;
  localparam int TDQ_REP_LSB  = 0;
  localparam int TDQ_TCNT_LSB = 16;
  localparam int TDQ_NOISE_B  = 21;
  localparam int TDQ_PEND_B   = 22;
  localparam int TDQ_FSEL_LSB = 24;

  // Reset values
  localparam logic [TDQ_SW-1:0]  TDQ_RST_THR  = 12'h040;
  localparam logic [TDQ_SW-1:0]  TDQ_RST_STHR = 12'h020;
  localparam logic [TDQ_SW-1:0]  TDQ_RST_GCL  = 12'h200;
  localparam logic [TDQ_CW-1:0]  TDQ_RST_LIM  = 4'h3;
  localparam logic [TDQ_TCW-1:0] TDQ_RST_MAXT = 5'h0A;
  localparam logic [TDQ_TCW-1:0] TDQ_RST_LRG  = 5'h06;
endpackage

//--- rtl/tdq_sup_if.sv
// Carries the touched vector and suppression settings between the
// qualifier core and the suppression stage. No clock inside.
`timescale 1ns/1ps
`default_nettype none
interface tdq_sup_if;
  import tdq_pkg::*;
  logic [TDQ_NCH-1:0] touched;
  logic               grip_en;
  logic [TDQ_NCH-1:0] grip_mask;
  logic [TDQ_TCW-1:0] max_touch;
  logic [TDQ_TCW-1:0] large_len;
  logic [TDQ_NCH-1:0] report;
  logic [TDQ_TCW-1:0] count;
  modport core (output touched, grip_en, grip_mask, max_touch, large_len,
                input report, count);
  modport sup  (input touched, grip_en, grip_mask, max_touch, large_len,
                output report, count);
endinterface
`default_nettype wire

//--- rtl/tdq_suppress.sv
// Touch suppression stage: grip border, large area and maximum count.
// Purely combinational; the caller registers its result.
`timescale 1ns/1ps
`default_nettype none
module tdq_suppress
  import tdq_pkg::*;
(
  tdq_sup_if.sup sif   // Touched vector in, reported vector out
);
  function automatic logic [TDQ_TCW-1:0] pop(input logic [TDQ_NCH-1:0] v);
    logic [TDQ_TCW-1:0] c;
    c = '0;
    for (int i = 0; i < TDQ_NCH; i++) begin
      c = c + TDQ_TCW'(v[i]);
    end
    return c;
  endfunction

  // Longest run of adjacent touched channels marks a broad contact
  function automatic logic [TDQ_TCW-1:0] lrun(input logic [TDQ_NCH-1:0] v);
    logic [TDQ_TCW-1:0] r;
    logic [TDQ_TCW-1:0] m;
    r = '0;
    m = '0;
    for (int i = 0; i < TDQ_NCH; i++) begin
      r = v[i] ? r + TDQ_TCW'(1) : '0;
      if (r > m) m = r;
    end
    return m;
  endfunction

  logic [TDQ_TCW-1:0] run;

  always_comb begin
    sif.count = pop(sif.touched);
    run = lrun(sif.touched);
    if (sif.count > sif.max_touch) begin
      sif.report = '0;
    end else if (sif.large_len != '0 && run >= sif.large_len) begin
      sif.report = '0;
    end else begin
      sif.report = sif.touched &
                   ~(sif.grip_en ? sif.grip_mask : '0);
    end
  end
endmodule // tdq_suppress
`default_nettype wire

//--- rtl/tdq_qualifier.sv
// Touch detection qualifier: per-channel integrator, noise filters,
// references, calibration, pins and Avalon-MM registers.
// Assumes samples arrive on CLK from the acquisition front end.
//
// Chosen here: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module tdq_qualifier
  import tdq_pkg::*;
(
  input  wire logic                CLK,                       // 20 MHz
  input  wire logic                RSTN,                      // Async reset
  input  wire logic [TDQ_AW-1:0]   AVS_ADDRESS,               // Byte address
  input  wire logic                AVS_READ,                  // Read request
  input  wire logic                AVS_WRITE,                 // Write request
  input  wire logic [31:0]         AVS_WRITEDATA,             // Write data
  input  wire logic [3:0]          AVS_BYTEENABLE,            // Byte lanes
  output logic      [31:0]         AVS_READDATA,              // Read data
  output logic                     AVS_WAITREQUEST,           // Stall
  input  wire logic                SMP_VALID,                 // Sample strobe
  input  wire logic [TDQ_CHW-1:0]  SMP_CH,                    // Channel
  input  wire logic [TDQ_SW-1:0]   SMP_RAW,                   // Raw value
  input  wire logic                SMP_STYLUS,                // Stylus class
  input  wire logic [TDQ_SW-1:0]   DISP_NOISE,                // Display noise
  input  wire logic                CHARGER_NOISE_TRIGGER_IN,  // Noise pin
  input  wire logic [TDQ_NGP-1:0]  GPIO_IN,                   // Pin levels
  output logic      [TDQ_NGP-1:0]  GPIO_OUT,                  // Pin drive
  output logic      [TDQ_NGP-1:0]  GPIO_OE_N,                 // Low drives
  output logic      [TDQ_NCH-1:0]  TOUCH_OUT,                 // Reported
  output logic                     NOISE_ACTIVE,              // Suppressing
  output logic                     DUAL_X_DRIVE,              // Paired drive
  output logic      [TDQ_FSW-1:0]  ACQ_SETTING                // Acq. index
);
  typedef struct packed {
    logic                           waitq;
    logic [31:0]                    rdata;
    logic [TDQ_CTRLW-1:0]           ctrl;
    logic [TDQ_SW-1:0]              thr;
    logic [TDQ_SW-1:0]              sthr;
    logic [TDQ_SW-1:0]              gcl;
    logic [TDQ_CW-1:0]              lim;
    logic [TDQ_TCW-1:0]             maxt;
    logic [TDQ_TCW-1:0]             lrg;
    logic [TDQ_NCH-1:0]             grip;
    logic [TDQ_NGP-1:0]             gpo;
    logic [TDQ_NGP-1:0]             goe_n;
    logic [1:0]                     chg_s;
    logic [TDQ_NGP-1:0]             gi_s1;
    logic [TDQ_NGP-1:0]             gi_s2;
    logic [TDQ_NCH-1:0][TDQ_CW-1:0] cnt;
    logic [TDQ_NCH-1:0][TDQ_SW-1:0] refv;
    logic [TDQ_NCH-1:0][TDQ_SW-1:0] fref;
    logic [TDQ_NCH-1:0]             touched;
    logic [TDQ_NCH-1:0]             pend;
    logic [TDQ_NCH-1:0]             rep;
    logic [TDQ_TCW-1:0]             tcnt;
    logic                           noise;
    logic [TDQ_FSW-1:0]             fsel;
    logic signed [TDQ_DW-1:0]       bend;
  } tdq_state_t;

  tdq_state_t s_r;
  tdq_state_t s_nxt;

  tdq_sup_if sif ();

  tdq_suppress u_sup (
    .sif (sif.sup)
  );

  assign sif.touched   = s_r.touched;
  assign sif.grip_en   = s_r.ctrl[TDQ_C_GRIP];
  assign sif.grip_mask = s_r.grip;
  assign sif.max_touch = s_r.maxt;
  assign sif.large_len = s_r.lrg;

  function automatic logic [31:0] be_merge(input logic [31:0] o,
                                           input logic [31:0] w,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = w[i*8 +: 8];
    end
    return r;
  endfunction

  logic                     req;
  logic                     wr;
  logic                     cal;
  logic                     noise_act;
  logic                     gc_use;
  logic                     oor;
  logic                     acc;
  logic                     det;
  logic [31:0]              rd_val;
  logic [31:0]              wv;
  logic [TDQ_CW-1:0]        cnt_sel;
  logic [TDQ_CW-1:0]        cnt_inc;
  logic signed [TDQ_DW-1:0] dref;
  logic signed [TDQ_DW-1:0] d0;
  logic signed [TDQ_DW-1:0] d;
  logic signed [TDQ_DW-1:0] thr_s;
  logic signed [TDQ_DW-1:0] adif;

  always_comb begin
    s_nxt = s_r;
    // Pin synchronisers
    s_nxt.chg_s = {s_r.chg_s[0], CHARGER_NOISE_TRIGGER_IN};
    s_nxt.gi_s1 = GPIO_IN;
    s_nxt.gi_s2 = s_r.gi_s1;

    // Register readback
    rd_val = '0;
    unique case (AVS_ADDRESS)
      TDQ_A_CTRL: rd_val[TDQ_CTRLW-1:0] = s_r.ctrl;
      TDQ_A_THR: begin
        rd_val[TDQ_THR_LSB +: TDQ_SW]  = s_r.thr;
        rd_val[TDQ_STHR_LSB +: TDQ_SW] = s_r.sthr;
      end
      TDQ_A_LIM: begin
        rd_val[TDQ_LIM_LSB +: TDQ_CW]   = s_r.lim;
        rd_val[TDQ_MAXT_LSB +: TDQ_TCW] = s_r.maxt;
        rd_val[TDQ_LRG_LSB +: TDQ_TCW]  = s_r.lrg;
      end
      TDQ_A_GCL:  rd_val[TDQ_SW-1:0] = s_r.gcl;
      TDQ_A_GRIP: rd_val[TDQ_NCH-1:0] = s_r.grip;
      TDQ_A_GPIO: begin
        rd_val[TDQ_GOUT_LSB +: TDQ_NGP] = s_r.gpo;
        rd_val[TDQ_GDIR_LSB +: TDQ_NGP] = ~s_r.goe_n;
        rd_val[TDQ_GIN_LSB +: TDQ_NGP]  = s_r.gi_s2;
      end
      TDQ_A_STAT: begin
        rd_val[TDQ_REP_LSB +: TDQ_NCH]  = s_r.rep;
        rd_val[TDQ_TCNT_LSB +: TDQ_TCW] = s_r.tcnt;
        rd_val[TDQ_NOISE_B]             = s_r.noise;
        rd_val[TDQ_PEND_B]              = |s_r.pend;
        rd_val[TDQ_FSEL_LSB +: TDQ_FSW] = s_r.fsel;
      end
      default: rd_val = '0;
    endcase

    // Bus handshake: one wait cycle, then the answer cycle
    req = AVS_READ | AVS_WRITE;
    s_nxt.waitq = 1'b1;
    if (req && s_r.waitq) begin
      s_nxt.waitq = 1'b0;
      s_nxt.rdata = AVS_READ ? rd_val : '0;
    end
    wr  = AVS_WRITE && !s_r.waitq;
    wv  = be_merge(rd_val, AVS_WRITEDATA, AVS_BYTEENABLE);
    cal = 1'b0;
    if (wr) begin
      unique case (AVS_ADDRESS)
        TDQ_A_CTRL: begin
          s_nxt.ctrl = wv[TDQ_CTRLW-1:0];
          cal        = wv[TDQ_C_CAL];
        end
        TDQ_A_THR: begin
          s_nxt.thr  = wv[TDQ_THR_LSB +: TDQ_SW];
          s_nxt.sthr = wv[TDQ_STHR_LSB +: TDQ_SW];
        end
        TDQ_A_LIM: begin
          s_nxt.lim  = wv[TDQ_LIM_LSB +: TDQ_CW];
          s_nxt.maxt = wv[TDQ_MAXT_LSB +: TDQ_TCW];
          s_nxt.lrg  = wv[TDQ_LRG_LSB +: TDQ_TCW];
        end
        TDQ_A_GCL:  s_nxt.gcl = wv[TDQ_SW-1:0];
        TDQ_A_GRIP: s_nxt.grip = wv[TDQ_NCH-1:0];
        TDQ_A_FACT:
          s_nxt.fref[wv[TDQ_FIDX_LSB +: TDQ_CHW]] =
            AVS_WRITEDATA[TDQ_FVAL_LSB +: TDQ_SW];
        TDQ_A_GPIO: begin
          s_nxt.gpo   = wv[TDQ_GOUT_LSB +: TDQ_NGP];
          s_nxt.goe_n = ~wv[TDQ_GDIR_LSB +: TDQ_NGP];
        end
        default: ;
      endcase
    end

    // Charger noise is independent of the display canceller
    noise_act = s_r.chg_s[1] | s_r.ctrl[TDQ_C_SWN];
    gc_use    = s_r.ctrl[TDQ_C_GC] & ~s_r.ctrl[TDQ_C_NC];

    // Sample path
    dref = $signed({2'b00, SMP_RAW}) - $signed({2'b00, s_r.refv[SMP_CH]});
    adif = dref[TDQ_DW-1] ? -dref : dref;
    oor  = adif > $signed({2'b00, s_r.gcl});
    d0   = dref - (s_r.ctrl[TDQ_C_NC] ?
                   $signed({2'b00, DISP_NOISE}) : '0);
    d    = d0 - (s_r.ctrl[TDQ_C_BEND] ? s_r.bend : '0);
    thr_s = $signed({2'b00, SMP_STYLUS ? s_r.sthr : s_r.thr});
    det  = d >= thr_s;
    cnt_sel = s_r.cnt[SMP_CH];
    cnt_inc = (cnt_sel >= s_r.lim) ? s_r.lim :
              cnt_sel + TDQ_CW'(1);
    acc  = SMP_VALID && !s_r.pend[SMP_CH] && !(gc_use && oor) && !cal;

    if (SMP_VALID) begin
      if (s_r.pend[SMP_CH]) begin
        // First sample after a calibration without CTRL FACT becomes the reference
        s_nxt.refv[SMP_CH]    = SMP_RAW;
        s_nxt.pend[SMP_CH]    = 1'b0;
        s_nxt.cnt[SMP_CH]     = '0;
        s_nxt.touched[SMP_CH] = 1'b0;
      end else if (gc_use && oor) begin
        if (noise_act) s_nxt.fsel = s_r.fsel + TDQ_FSW'(1);
      end else begin
        if (det) begin
          s_nxt.cnt[SMP_CH]     = cnt_inc;
          s_nxt.touched[SMP_CH] = cnt_inc == s_r.lim;
        end else begin
          s_nxt.cnt[SMP_CH]     = '0;
          s_nxt.touched[SMP_CH] = 1'b0;
        end
        if (s_r.ctrl[TDQ_C_BEND] && !s_r.touched[SMP_CH]) begin
          s_nxt.bend = s_r.bend +
                       ((d0 - s_r.bend) >>> TDQ_BEND_SHIFT);
        end
      end
    end

    if (cal) begin
      s_nxt.cnt     = '0;
      s_nxt.touched = '0;
      if (s_r.ctrl[TDQ_C_FACT]) begin
        s_nxt.refv = s_r.fref;
        s_nxt.pend = '0;
      end else begin
        s_nxt.pend = '1;
      end
    end

    s_nxt.rep   = sif.report;
    s_nxt.tcnt  = sif.count;
    s_nxt.noise = noise_act;
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      s_r       <= '0;
      s_r.waitq <= 1'b1;
      s_r.thr   <= TDQ_RST_THR;
      s_r.sthr  <= TDQ_RST_STHR;
      s_r.gcl   <= TDQ_RST_GCL;
      s_r.lim   <= TDQ_RST_LIM;
      s_r.maxt  <= TDQ_RST_MAXT;
      s_r.lrg   <= TDQ_RST_LRG;
      s_r.goe_n <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign AVS_READDATA    = s_r.rdata;
  assign AVS_WAITREQUEST = s_r.waitq;
  assign GPIO_OUT        = s_r.gpo;
  assign GPIO_OE_N       = s_r.goe_n;
  assign TOUCH_OUT       = s_r.rep;
  assign NOISE_ACTIVE    = s_r.noise;
  assign DUAL_X_DRIVE    = s_r.ctrl[TDQ_C_DUALX];
  assign ACQ_SETTING     = s_r.fsel;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sequence s_bus_req;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence s_bus_done;
    !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endsequence
  sequence s_hit;
    acc && det;
  endsequence

  a_bus_answer: assert property (s_bus_req |=> s_bus_done)
    else $error("bus answer not after one wait cycle");
  a_count_inc: assert property (
    s_hit and (cnt_sel < s_r.lim) |=>
      s_r.cnt[$past(SMP_CH)] == $past(cnt_sel) + TDQ_CW'(1))
    else $error("counter did not step on detect");
  a_touch_declare: assert property (
    s_hit and (cnt_sel + TDQ_CW'(1) == s_r.lim) |=>
      s_r.touched[$past(SMP_CH)])
    else $error("touch not declared at limit");
  a_count_clear: assert property (
    acc && !det |=> s_r.cnt[$past(SMP_CH)] == '0 &&
                    !s_r.touched[$past(SMP_CH)])
    else $error("counter not cleared on miss");
  a_count_sat: assert property (
    s_hit and (cnt_sel == s_r.lim) |=>
      s_r.cnt[$past(SMP_CH)] == $past(cnt_sel))
    else $error("counter passed the limit");
  a_range_drop: assert property (
    SMP_VALID && !s_r.pend[SMP_CH] && gc_use && oor && !cal |=>
      $stable(s_r.cnt) && $stable(s_r.touched))
    else $error("out-of-range sample was counted");
  a_noise_start: assert property (
    $rose(CHARGER_NOISE_TRIGGER_IN) |-> ##[2:3] NOISE_ACTIVE)
    else $error("noise pin did not start suppression");
  a_canceller_nogc: assert property (
    SMP_VALID && s_r.ctrl[TDQ_C_NC] && !s_r.pend[SMP_CH] && !cal && oor &&
      det |=> s_r.cnt[$past(SMP_CH)] == $past(cnt_inc))
    else $error("range filter acted under canceller");
  a_max_touch: assert property (
    sif.count > s_r.maxt |=> TOUCH_OUT == '0)
    else $error("touches reported above maximum");
  a_grip_border: assert property (
    s_r.ctrl[TDQ_C_GRIP] |=> (TOUCH_OUT & $past(s_r.grip)) == '0)
    else $error("border touch reported under grip");
  a_cal_factory: assert property (
    cal && s_r.ctrl[TDQ_C_FACT] |=> s_r.refv == $past(s_r.fref) &&
                                     s_r.cnt == '0)
    else $error("factory references not restored");
endmodule // tdq_qualifier
`default_nettype wire

//--- bench/tdq_acq_model.sv
// Acquisition front end model: sends sample strobes to the qualifier.
// Assumes one bench process calls send; outputs change after rising edges.
`timescale 1ns/1ps
`default_nettype none
module tdq_acq_model
  import tdq_pkg::*;
(
  input  wire logic          clk,        // Bench clock
  output logic               smp_valid,  // Sample strobe
  output logic [TDQ_CHW-1:0] smp_ch,     // Channel
  output logic [TDQ_SW-1:0]  smp_raw,    // Raw value
  output logic               smp_stylus, // Stylus class
  output logic [TDQ_SW-1:0]  disp_noise  // Display noise
);
  initial begin
    smp_valid  = 1'b0;
    smp_ch     = '0;
    smp_raw    = '0;
    smp_stylus = 1'b0;
    disp_noise = '0;
  end

  // Between strobes the qualifiers toggle, so a stale value never counts
  task automatic drift();
    smp_valid  <= 1'b0;
    smp_ch     <= ~smp_ch;
    smp_raw    <= ~smp_raw;
    smp_stylus <= ~smp_stylus;
    disp_noise <= ~disp_noise;
  endtask

  task automatic send(input logic [TDQ_CHW-1:0] c,
                      input logic [TDQ_SW-1:0]  r,
                      input logic               s,
                      input logic [TDQ_SW-1:0]  d,
                      input int                 n,
                      input int                 gap);
    repeat (n) begin
      @(posedge clk);
      smp_valid  <= 1'b1;
      smp_ch     <= c;
      smp_raw    <= r;
      smp_stylus <= s;
      disp_noise <= d;
      repeat (gap) begin
        @(posedge clk);
        drift();
      end
    end
    @(posedge clk);
    drift();
  endtask
endmodule // tdq_acq_model
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for the touch detection qualifier.
// Assumes the Avalon slave answers after waitrequest drops, refs 0 at reset.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import tdq_pkg::*;
;
  typedef struct packed {
    logic        port;
    logic [31:0] m;
    logic [31:0] e;
  } tdq_note_t;
  localparam logic [31:0] TMASK = 32'h0000_FFFF;
  tdq_note_t          notes[$];
  tdq_note_t          cur;
  int                 bad_count, comparisons, cyc;
  logic               clk, rstn, rd, wr, look, chg, wreq, noise, dual;
  logic [7:0]         adr;
  logic [31:0]        wdat, rdat, got, rnd;
  logic [3:0]         be;
  logic [2:0]         gin, gout, goen, acq;
  logic [15:0]        tout;
  logic               sv, ssty;
  logic [3:0]         sch;
  logic [11:0]        sraw, dn;
  wire  logic [31:0]  pv = {5'h00, acq, dual, noise, goen, gout, tout};

  always #25 clk = ~clk;

  tdq_acq_model tdq_acq_model_i (.clk(clk), .smp_valid(sv), .smp_ch(sch),
    .smp_raw(sraw), .smp_stylus(ssty), .disp_noise(dn));
  tdq_qualifier tdq_qualifier_i (.CLK(clk), .RSTN(rstn), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat),
    .AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
    .SMP_VALID(sv), .SMP_CH(sch), .SMP_RAW(sraw), .SMP_STYLUS(ssty),
    .DISP_NOISE(dn), .CHARGER_NOISE_TRIGGER_IN(chg), .GPIO_IN(gin),
    .GPIO_OUT(gout), .GPIO_OE_N(goen), .TOUCH_OUT(tout),
    .NOISE_ACTIVE(noise), .DUAL_X_DRIVE(dual), .ACQ_SETTING(acq));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Random finger value at or above threshold and inside the range limit
  function automatic logic [11:0] rv();
    rnd = lfsr(rnd);
    return 12'h040 + {4'h0, rnd[7:0]};
  endfunction

  task automatic print_verdict();
    $display("Mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    @(posedge clk);
    wr   <= w;
    rd   <= ~w;
    adr  <= a;
    wdat <= d;
    be   <= b;
    do @(posedge clk); while (wreq !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, e);
    notes.push_back('{1'b0, m, e});
    bus(1'b0, a, 32'h0000_0000, 4'hF);
  endtask

  // Port snapshot is taken at the edge where look is seen high
  task automatic pchk(input logic [31:0] m, e);
    notes.push_back('{1'b1, m, e});
    @(posedge clk);
    look <= 1'b1;
    @(posedge clk);
    look <= 1'b0;
  endtask

  task automatic smp(input logic [3:0] c, input logic [11:0] r,
                     input logic s, input logic [11:0] d, input int n);
    rnd = lfsr(rnd);
    tdq_acq_model_i.send(c, r, s, d, n, int'(rnd[1:0]) % 3);
  endtask

  always @(posedge clk) begin
    if ((rd && wreq === 1'b0) || look) begin
      got = look ? pv : rdat;
      cur = notes.pop_front();
      comparisons++;
      if (((got & cur.m) !== cur.e) || cur.port !== look) begin
        bad_count++;
        $display("ERROR t=%0t got %h exp %h", $time, got & cur.m, cur.e);
      end
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  initial begin
    clk = 1'b0; rstn = 1'b0; rd = 1'b0; wr = 1'b0; look = 1'b0;
    adr = '0; wdat = '0; be = '0; chg = 1'b0; gin = 3'b101;
    rnd = 32'h0000_703B; bad_count = 0; comparisons = 0; cyc = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rchk(TDQ_A_THR, '1, 32'h0020_0040);
    rchk(TDQ_A_LIM, '1, 32'h0006_0A03);
    rchk(TDQ_A_GCL, '1, 32'h0000_0200);
    rchk(TDQ_A_CTRL, '1, 32'h0000_0000);
    rchk(TDQ_A_GPIO, 32'h0000_0777, 32'h0000_0500);
    wreg(8'h20, 32'hFFFF_FFFF);
    rchk(8'h20, '1, 32'h0000_0000);
    smp(4'h2, rv(), 1'b0, 12'h000, 2);
    pchk(TMASK, 32'h0000_0000);
    smp(4'h2, rv(), 1'b0, 12'h000, 1);
    pchk(TMASK, 32'h0000_0004);
    smp(4'h2, rv(), 1'b0, 12'h000, 3);
    pchk(TMASK, 32'h0000_0004);
    rchk(TDQ_A_STAT, 32'h001F_FFFF, 32'h0001_0004);
    smp(4'h3, rv(), 1'b0, 12'h000, 2);
    smp(4'h3, 12'h03F, 1'b0, 12'h000, 1);
    smp(4'h3, 12'h040, 1'b0, 12'h000, 2);
    pchk(TMASK, 32'h0000_0004);
    smp(4'h3, 12'h040, 1'b0, 12'h000, 1);
    pchk(TMASK, 32'h0000_000C);
    smp(4'h5, 12'h030, 1'b1, 12'h000, 3);
    smp(4'h6, 12'h030, 1'b0, 12'h000, 3);
    pchk(TMASK, 32'h0000_002C);
    wreg(TDQ_A_LIM, 32'h0002_0A03);
    pchk(TMASK, 32'h0000_0000);
    wreg(TDQ_A_LIM, 32'h0000_0203);
    pchk(TMASK, 32'h0000_0000);
    wreg(TDQ_A_LIM, 32'h0000_0303);
    pchk(TMASK, 32'h0000_002C);
    wreg(TDQ_A_LIM, 32'h0000_0A03);
    wreg(TDQ_A_GRIP, 32'h0000_0004);
    pchk(TMASK, 32'h0000_002C);
    wreg(TDQ_A_CTRL, 32'h0000_0010);
    pchk(TMASK, 32'h0000_0028);
    bus(1'b1, TDQ_A_THR, 32'hFFFF_FF80, 4'h1);
    rchk(TDQ_A_THR, '1, 32'h0020_0080);
    wreg(TDQ_A_THR, 32'h0020_0040);
    wreg(TDQ_A_CTRL, 32'h0000_0001);
    smp(4'h7, 12'h300, 1'b0, 12'h000, 3);
    pchk(TMASK, 32'h0000_002C);
    wreg(TDQ_A_CTRL, 32'h0000_0021);
    pchk(32'h0740_0000, 32'h0040_0000);
    smp(4'h7, 12'h300, 1'b0, 12'h000, 2);
    pchk(32'h0740_0000, 32'h0240_0000);
    wreg(TDQ_A_CTRL, 32'h0000_0023);
    smp(4'h8, 12'h0A0, 1'b0, 12'h070, 3);
    smp(4'h7, 12'h300, 1'b0, 12'h000, 3);
    pchk(32'h0740_FFFF, 32'h0240_00AC);
    smp(4'h8, 12'h0B0, 1'b0, 12'h070, 3);
    pchk(TMASK, 32'h0000_01AC);
    wreg(TDQ_A_CTRL, 32'h0000_0003);
    pchk(32'h0040_0000, 32'h0000_0000);
    chg <= 1'b1;
    repeat (4) @(posedge clk);
    pchk(32'h0040_0000, 32'h0040_0000);
    chg <= 1'b0;
    wreg(TDQ_A_CTRL, 32'h0000_0008);
    pchk(32'h0080_0000, 32'h0080_0000);
    wreg(TDQ_A_GPIO, 32'h0000_0053);
    gin <= 3'b010;
    repeat (3) @(posedge clk);
    pchk(32'h003F_0000, 32'h0013_0000);
    rchk(TDQ_A_GPIO, 32'h0000_0777, 32'h0000_0253);
    smp(4'h9, rv(), 1'b0, 12'h000, 2);
    wreg(TDQ_A_FACT, 32'h0002_0100);
    wreg(TDQ_A_CTRL, 32'h0000_0004);
    wreg(TDQ_A_CTRL, 32'h0000_0084);
    rchk(TDQ_A_CTRL, 32'h0000_00FF, 32'h0000_0004);
    rchk(TDQ_A_FACT, '1, 32'h0000_0000);
    smp(4'h9, rv(), 1'b0, 12'h000, 1);
    pchk(32'h0000_0200, 32'h0000_0000);
    smp(4'h2, 12'h130, 1'b0, 12'h000, 3);
    pchk(32'h0000_0004, 32'h0000_0000);
    smp(4'h2, 12'h150, 1'b0, 12'h000, 3);
    pchk(32'h0000_0004, 32'h0000_0004);
    wreg(TDQ_A_CTRL, 32'h0000_0044);
    smp(4'hA, 12'h030, 1'b0, 12'h000, 8);
    smp(4'hB, 12'h050, 1'b0, 12'h000, 3);
    pchk(32'h0000_0800, 32'h0000_0000);
    wreg(TDQ_A_CTRL, 32'h0000_0004);
    smp(4'hB, 12'h050, 1'b0, 12'h000, 3);
    pchk(32'h0000_0800, 32'h0000_0800);
    wreg(TDQ_A_CTRL, 32'h0000_0000);
    wreg(TDQ_A_CTRL, 32'h0000_0080);
    rchk(TDQ_A_STAT, 32'h0040_0000, 32'h0040_0000);
    smp(4'h2, 12'h150, 1'b0, 12'h000, 3);
    pchk(32'h0000_0004, 32'h0000_0000);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rchk(TDQ_A_LIM, '1, 32'h0006_0A03);
    pchk(32'h07FF_FFFF, 32'h0038_0000);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
